// ### fsw_top.sv
// Purpose: Fault handling for an I/O board: halt line, watchdog, safe output states
// Assumes: AXI4-Lite register access, 40 MHz clock, inputs synchronous to clk_i
// Notes: A latched shutdown fault is left only through reset (power cycle)
`timescale 1ns/1ps
`default_nettype none
`include "fsw_cfg.svh"
module fsw_top #(
    parameter int N_TTL_OUT = 10,
    parameter int N_ISO_OUT = 4,
    parameter int N_TTL_IN = 2,
    parameter int N_ISO_IN = 13,
    parameter int CYC_PER_MS = (`FSW_TICK_MS * `FSW_NS_PER_MS) / `FSW_CLK_PERIOD_NS
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire fsw_pkg::fsw_axi_req_t axi_req_i,
    output fsw_pkg::fsw_axi_rsp_t axi_rsp_o,
    input wire logic [N_TTL_IN-1:0] ttl_in_i,
    input wire logic [N_ISO_IN-1:0] iso_in_i,
    input wire logic halt_line_i,
    output logic [N_TTL_OUT-1:0] ttl_out_o,
    output logic [N_TTL_OUT-1:0] ttl_oe_o,
    output logic [N_ISO_OUT-1:0] iso_out_o,
    output logic proc_halt_o,
    output logic irq_o
);
    import fsw_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Byte-lane merge of a write into a register word
    function automatic logic [31:0] fsw_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Address decode shared by read and write paths
    function automatic logic fsw_mapped(input logic [7:0] a);
        case (a)
            `FSW_OFS_CTRL, `FSW_OFS_WD_TIMEOUT, `FSW_OFS_WD_FEED, `FSW_OFS_STATUS,
            `FSW_OFS_GPO_TTL, `FSW_OFS_GPO_ISO, `FSW_OFS_GPI, `FSW_OFS_SAFE_TTL,
            `FSW_OFS_SAFE_ISO, `FSW_OFS_IRQ_STAT, `FSW_OFS_IRQ_MASK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    fsw_ctrl_t ctrl;
    logic [15:0] wd_timeout;
    logic [N_TTL_OUT-1:0] gpo_ttl;
    logic [N_ISO_OUT-1:0] gpo_iso;
    logic [2*N_TTL_OUT-1:0] safe_ttl;
    logic [N_ISO_OUT-1:0] safe_iso;
    logic [`FSW_IRQ_W-1:0] irq_stat;
    logic [`FSW_IRQ_W-1:0] irq_mask;
    logic locked;
    logic halt_flt;
    logic wd_flag;
    logic wd_expired;
    logic wd_expired_d;
    logic wd_feed;
    logic halt_now;
    logic wd_shdn_now;
    logic [`FSW_IRQ_W-1:0] irq_set;
    logic aw_held, aw_rdy, w_rdy, ar_rdy;
    logic w_held, b_valid, r_valid;
    logic [1:0] b_resp, r_resp;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic [31:0] wr_old;
    logic [31:0] wr_val;
    logic [31:0] rd_word, r_data;
    logic [31:0] gpi_word;
    logic [31:0] status_word;

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    // Accept address and data in either order, one write at a time
    assign aw_rdy = !aw_held && !b_valid;
    assign w_rdy = !w_held && !b_valid;
    assign wr_fire = aw_held && w_held && !b_valid;

    // Hold write address
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (axi_req_i.awvalid && aw_rdy) begin
            aw_held <= 1'b1;
            aw_addr <= {axi_req_i.awaddr[7:2], 2'b00};
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // Hold write data and strobes
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            w_held <= 1'b0;
            w_data <= `FSW_RST_ZERO;
            w_strb <= 4'h0;
        end else if (axi_req_i.wvalid && w_rdy) begin
            w_held <= 1'b1;
            w_data <= axi_req_i.wdata;
            w_strb <= axi_req_i.wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // Write response, error on unmapped or read-only offsets
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            b_valid <= 1'b0;
            b_resp <= `FSW_RESP_OKAY;
        end else if (wr_fire) begin
            b_valid <= 1'b1;
            b_resp <= (fsw_mapped(aw_addr) && aw_addr != `FSW_OFS_STATUS &&
                       aw_addr != `FSW_OFS_GPI) ? `FSW_RESP_OKAY : `FSW_RESP_SLVERR;
        end else if (axi_req_i.bready) begin
            b_valid <= 1'b0;
        end
    end

    // Current word of the target register for byte merging
    always_comb begin
        wr_old = `FSW_RST_ZERO;
        case (aw_addr)
            `FSW_OFS_CTRL: wr_old = 32'(ctrl);
            `FSW_OFS_WD_TIMEOUT: wr_old = 32'(wd_timeout);
            `FSW_OFS_GPO_TTL: wr_old = 32'(gpo_ttl);
            `FSW_OFS_GPO_ISO: wr_old = 32'(gpo_iso);
            `FSW_OFS_SAFE_TTL: wr_old = 32'(safe_ttl);
            `FSW_OFS_SAFE_ISO: wr_old = 32'(safe_iso);
            `FSW_OFS_IRQ_MASK: wr_old = 32'(irq_mask);
            default: wr_old = `FSW_RST_ZERO;
        endcase
    end
    assign wr_val = fsw_merge(wr_old, w_data, w_strb);
    assign wd_feed = wr_fire && aw_addr == `FSW_OFS_WD_FEED;

    // ****************************************************************
    // Software registers
    // ****************************************************************

    // Control word; shutdown enable cannot be dropped once locked
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl <= fsw_ctrl_t'(`FSW_RST_CTRL);
        end else if (wr_fire && aw_addr == `FSW_OFS_CTRL) begin
            ctrl.arm <= wr_val[`FSW_CTRL_ARM];
            ctrl.act <= fsw_act_t'(wr_val[`FSW_CTRL_ACT_HI:`FSW_CTRL_ACT_LO]);
            ctrl.shdn_en <= wr_val[`FSW_CTRL_SHDN_EN] | locked;
        end
    end

    // Timeout, clamped to 1..65534 ms
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wd_timeout <= `FSW_RST_TIMEOUT;
        end else if (wr_fire && aw_addr == `FSW_OFS_WD_TIMEOUT) begin
            if (wr_val[15:0] > `FSW_TIMEOUT_MAX) begin
                wd_timeout <= `FSW_TIMEOUT_MAX;
            end else if (wr_val[15:0] == 16'h0000) begin
                wd_timeout <= 16'h0001;
            end else begin
                wd_timeout <= wr_val[15:0];
            end
        end
    end

    // General outputs, changed only by software writes
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            gpo_ttl <= '0;
            gpo_iso <= '0;
        end else if (wr_fire && aw_addr == `FSW_OFS_GPO_TTL) begin
            gpo_ttl <= wr_val[N_TTL_OUT-1:0];
        end else if (wr_fire && aw_addr == `FSW_OFS_GPO_ISO) begin
            gpo_iso <= wr_val[N_ISO_OUT-1:0];
        end
    end

    // Safe state configuration
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            safe_ttl <= '0;
            safe_iso <= '0;
        end else if (wr_fire && aw_addr == `FSW_OFS_SAFE_TTL) begin
            safe_ttl <= wr_val[2*N_TTL_OUT-1:0];
        end else if (wr_fire && aw_addr == `FSW_OFS_SAFE_ISO) begin
            safe_iso <= wr_val[N_ISO_OUT-1:0];
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_mask <= '0;
        end else if (wr_fire && aw_addr == `FSW_OFS_IRQ_MASK) begin
            irq_mask <= wr_val[`FSW_IRQ_W-1:0];
        end
    end

    // ****************************************************************
    // Watchdog and fault detection
    // ****************************************************************
    fsw_wdog_timer #(
        .CYC_PER_MS(CYC_PER_MS),
        .CNT_W(16)
    ) u_wdog (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .arm_i(ctrl.arm),
        .feed_i(wd_feed),
        .timeout_i(wd_timeout),
        .expired_o(wd_expired)
    );

    // Fault events: halt line off while enabled, expiry in shutdown action
    assign halt_now = ctrl.shdn_en && !halt_line_i;
    assign wd_shdn_now = ctrl.shdn_en && wd_expired && ctrl.act == FSW_ACT_SHDN;

    // Sticky fault state, left only by reset
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            locked <= 1'b0;
            halt_flt <= 1'b0;
        end else begin
            if (halt_now || wd_shdn_now) begin
                locked <= 1'b1;
            end
            if (halt_now) begin
                halt_flt <= 1'b1;
            end
        end
    end

    // Expiry flag, visible in flag action, cleared by disarm inside the timer
    assign wd_flag = wd_expired && ctrl.act == FSW_ACT_FLAG;

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wd_expired_d <= 1'b0;
        end else begin
            wd_expired_d <= wd_expired;
        end
    end
    assign irq_set = {halt_now && !halt_flt, wd_expired && !wd_expired_d};

    // Sticky status, write one clears, set wins
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_stat <= '0;
        end else if (wr_fire && aw_addr == `FSW_OFS_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~wr_val[`FSW_IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat <= irq_stat | irq_set;
        end
    end
    assign irq_o = |(irq_stat & irq_mask);

    // ****************************************************************
    // Output drive
    // ****************************************************************

    // Safe states when locked, else software levels and watchdog line
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ttl_out_o <= '0;
            ttl_oe_o <= '1;
            iso_out_o <= '0;
        end else if (locked) begin
            for (int i = 0; i < N_TTL_OUT; i++) begin
                ttl_out_o[i] <= (fsw_safe_t'(safe_ttl[2*i +: 2]) == FSW_SAFE_HIGH);
                ttl_oe_o[i] <= (fsw_safe_t'(safe_ttl[2*i +: 2]) != FSW_SAFE_HIZ);
            end
            iso_out_o <= safe_iso;
        end else begin
            ttl_out_o <= gpo_ttl;
            ttl_oe_o <= '1;
            iso_out_o <= gpo_iso;
            if (ctrl.act == FSW_ACT_TTL0 && ctrl.arm) begin
                ttl_out_o[0] <= wd_expired;
            end
        end
    end

    // Processing stop on external halt
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            proc_halt_o <= 1'b0;
        end else begin
            proc_halt_o <= halt_flt;
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    // General inputs are plain level samples
    assign gpi_word = 32'({halt_line_i, iso_in_i, ttl_in_i});
    assign status_word = 32'({wd_expired, !halt_line_i, halt_flt, wd_flag, locked});

    // Read word selection
    always_comb begin
        rd_word = `FSW_RST_ZERO;
        case (axi_req_i.araddr & 8'hfc)
            `FSW_OFS_CTRL: rd_word = 32'(ctrl);
            `FSW_OFS_WD_TIMEOUT: rd_word = 32'(wd_timeout);
            `FSW_OFS_STATUS: rd_word = status_word;
            `FSW_OFS_GPO_TTL: rd_word = 32'(gpo_ttl);
            `FSW_OFS_GPO_ISO: rd_word = 32'(gpo_iso);
            `FSW_OFS_GPI: rd_word = gpi_word;
            `FSW_OFS_SAFE_TTL: rd_word = 32'(safe_ttl);
            `FSW_OFS_SAFE_ISO: rd_word = 32'(safe_iso);
            `FSW_OFS_IRQ_STAT: rd_word = 32'(irq_stat);
            `FSW_OFS_IRQ_MASK: rd_word = 32'(irq_mask);
            default: rd_word = `FSW_RST_ZERO;
        endcase
    end

    // One read at a time, data from a register; answers gathered onto the port
    assign ar_rdy = !r_valid;
    assign axi_rsp_o = {aw_rdy, w_rdy, b_valid, b_resp, ar_rdy, r_valid, r_data, r_resp};
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            r_valid <= 1'b0;
            r_data <= `FSW_RST_ZERO;
            r_resp <= `FSW_RESP_OKAY;
        end else if (axi_req_i.arvalid && ar_rdy) begin
            r_valid <= 1'b1;
            r_data <= rd_word;
            r_resp <= fsw_mapped(axi_req_i.araddr & 8'hfc) ?
                      `FSW_RESP_OKAY : `FSW_RESP_SLVERR;
        end else if (axi_req_i.rready) begin
            r_valid <= 1'b0;
        end
    end

endmodule // fsw_top
`default_nettype wire

// ### fsw_cfg.svh
// Purpose: Constants of the fault shutdown watchdog: offsets, fields, resets, timing
// Assumes: 32-bit AXI4-Lite register bus, 40 MHz clock
// Notes: Definitions only
`ifndef FSW_CFG_SVH
`define FSW_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define FSW_OFS_CTRL 8'h00
`define FSW_OFS_WD_TIMEOUT 8'h04
`define FSW_OFS_WD_FEED 8'h08
`define FSW_OFS_STATUS 8'h0c
`define FSW_OFS_GPO_TTL 8'h10
`define FSW_OFS_GPO_ISO 8'h14
`define FSW_OFS_GPI 8'h18
`define FSW_OFS_SAFE_TTL 8'h1c
`define FSW_OFS_SAFE_ISO 8'h20
`define FSW_OFS_IRQ_STAT 8'h24
`define FSW_OFS_IRQ_MASK 8'h28

// ****************************************************************
// Field positions
// ****************************************************************
`define FSW_CTRL_SHDN_EN 0
`define FSW_CTRL_ACT_LO 1
`define FSW_CTRL_ACT_HI 2
`define FSW_CTRL_ARM 3
`define FSW_ST_LOCKED 0
`define FSW_ST_WD_FLAG 1
`define FSW_ST_HALT_FLT 2
`define FSW_ST_HALT_LVL 3
`define FSW_ST_WD_EXP 4
`define FSW_IRQ_WD 0
`define FSW_IRQ_HALT 1
`define FSW_IRQ_W 2

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define FSW_RST_CTRL 4'h0
`define FSW_RST_TIMEOUT 16'hfffe
`define FSW_RST_ZERO 32'h0000_0000
`define FSW_RESP_OKAY 2'b00
`define FSW_RESP_SLVERR 2'b10
`define FSW_TIMEOUT_MAX 16'hfffe

// ****************************************************************
// Timing
// ****************************************************************
`define FSW_TICK_MS 1
`define FSW_CLK_PERIOD_NS 25
`define FSW_NS_PER_MS 1000000

`endif

// ### fsw_pkg.sv
// Purpose: Types shared by the fault shutdown watchdog files
// Assumes: Included constants from fsw_cfg.svh
// Notes: Types only
`default_nettype none
package fsw_pkg;

    // Watchdog expiry action
    typedef enum logic [1:0] {
        FSW_ACT_FLAG = 2'b00,
        FSW_ACT_TTL0 = 2'b01,
        FSW_ACT_SHDN = 2'b10
    } fsw_act_t;

    // Safe state of one TTL output
    typedef enum logic [1:0] {
        FSW_SAFE_LOW = 2'b00,
        FSW_SAFE_HIGH = 2'b01,
        FSW_SAFE_HIZ = 2'b10
    } fsw_safe_t;

    // Software control word
    typedef struct packed {
        logic arm;
        fsw_act_t act;
        logic shdn_en;
    } fsw_ctrl_t;

    // AXI4-Lite request side
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } fsw_axi_req_t;

    // AXI4-Lite answer side
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fsw_axi_rsp_t;

endpackage
`default_nettype wire

// ### fsw_wdog_timer.sv
// Purpose: Millisecond watchdog counter with sticky expiry
// Assumes: Synchronous active-low reset, one clock
// Notes: Expiry holds until disarm
`timescale 1ns/1ps
`default_nettype none
`include "fsw_cfg.svh"
module fsw_wdog_timer #(
    parameter int CYC_PER_MS = 40000,
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic arm_i,
    input wire logic feed_i,
    input wire logic [CNT_W-1:0] timeout_i,
    output logic expired_o
);
    import fsw_pkg::*;

    logic [31:0] pre;
    logic [CNT_W-1:0] ms_cnt;
    logic tick;

    // Millisecond tick prescaler, restarted by arm or feed
    assign tick = (pre == 32'(CYC_PER_MS - 1));
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !arm_i || feed_i || tick) begin
            pre <= 32'h0000_0000;
        end else begin
            pre <= pre + 32'h0000_0001;
        end
    end

    // Millisecond count, feed reloads to zero
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !arm_i || feed_i) begin
            ms_cnt <= '0;
        end else if (tick && !expired_o) begin
            ms_cnt <= ms_cnt + CNT_W'(1);
        end
    end

    // Sticky expiry, cleared only by disarm
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !arm_i) begin
            expired_o <= 1'b0;
        end else if (ms_cnt >= timeout_i) begin
            expired_o <= 1'b1;
        end
    end

endmodule // fsw_wdog_timer
`default_nettype wire

// ### fsw_top_sva.sv
// Purpose: Assertions on the ports of the fault shutdown watchdog
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to fsw_top after the module
`timescale 1ns/1ps
`default_nettype none
module fsw_top_sva #(
    parameter int N_TTL_OUT = 10
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire fsw_pkg::fsw_axi_req_t axi_req_i,
    input wire fsw_pkg::fsw_axi_rsp_t axi_rsp_o,
    input wire logic halt_line_i,
    input wire logic [N_TTL_OUT-1:0] ttl_oe_o,
    input wire logic proc_halt_o,
    input wire logic irq_o
);
    import fsw_pkg::*;
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_rst;
        disable iff (1'b0) !rstn_i |=> &ttl_oe_o && !proc_halt_o && !irq_o;
    endproperty
    property p_lock;
        proc_halt_o |=> proc_halt_o;
    endproperty
    property p_halt_cause;
        $rose(proc_halt_o) |-> $past(!halt_line_i, 2);
    endproperty
    property p_b_hold;
        axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp);
    endproperty
    property p_r_hold;
        axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata);
    endproperty
    property p_ar_ans;
        axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid;
    endproperty
    property p_w_ref;
        axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready;
    endproperty
    property p_b_ans;
        axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready
            |-> ##[1:3] axi_rsp_o.bvalid;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    a_lock: assert property (p_lock) else $error("halt fault left");
    a_halt_cause: assert property (p_halt_cause) else $error("halt without cause");
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
    a_w_ref: assert property (p_w_ref) else $error("write taken while answering");
    a_b_ans: assert property (p_b_ans) else $error("write answer late");
    // Main scenarios
    c_halt: cover property ($rose(proc_halt_o));
    c_irq: cover property ($rose(irq_o));
    c_err: cover property (axi_rsp_o.bvalid && axi_rsp_o.bresp == 2'h2);
endmodule // fsw_top_sva
bind fsw_top fsw_top_sva #(.N_TTL_OUT(N_TTL_OUT)) fsw_top_sva_inst (.clk_i(clk_i),
    .rstn_i(rstn_i), .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o),
    .halt_line_i(halt_line_i), .ttl_oe_o(ttl_oe_o), .proc_halt_o(proc_halt_o), .irq_o(irq_o));
`default_nettype wire

// ### fsw_halt_src.sv
// Purpose: External equipment driving the halt line
// Assumes: Moves just after a rising edge
// Notes: Line on (run) unless asked to halt
`timescale 1ns/1ps
`default_nettype none
module fsw_halt_src (
    input wire logic clk_i,
    input wire logic off_i,
    output logic halt_line_o
);
    // Halt request is the line going off
    initial halt_line_o = 1'b1;
    always @(posedge clk_i) begin
        halt_line_o <= !off_i;
    end
endmodule // fsw_halt_src
`default_nettype wire

// ### fsw_top_test.sv
// Purpose: Self-checking bench of the fault shutdown watchdog
// Assumes: Short millisecond (4 cycles) for speed
// Notes: Bus answers compared from a queue
`timescale 1ns/1ps
`default_nettype none
`include "fsw_cfg.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fsw_top_test;
    import fsw_pkg::*;
    localparam logic [1:0] OK = `FSW_RESP_OKAY;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    fsw_axi_req_t req = '0;
    fsw_axi_rsp_t rsp;
    logic [1:0] ttl_in = '0;
    logic [12:0] iso_in = '0;
    logic halt_off = 1'b0;
    logic halt_line, proc_halt, irq;
    logic [9:0] ttl_out, ttl_oe, e_out, e_oe;
    logic [3:0] iso_out;
    logic [33:0] q[$];
    logic [33:0] exp;
    logic [31:0] v;
    logic [19:0] safe = 20'h64924;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    // ****************************************************************
    // Clock, instances, timeout, monitor
    // ****************************************************************
    always #12.5 clk_i = ~clk_i;
    fsw_top #(.CYC_PER_MS(4)) fsw_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .axi_req_i(req),
        .axi_rsp_o(rsp), .ttl_in_i(ttl_in), .iso_in_i(iso_in), .halt_line_i(halt_line),
        .ttl_out_o(ttl_out), .ttl_oe_o(ttl_oe), .iso_out_o(iso_out),
        .proc_halt_o(proc_halt), .irq_o(irq));
    fsw_halt_src fsw_halt_src_inst (.clk_i(clk_i), .off_i(halt_off), .halt_line_o(halt_line));
    // Hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    // Oldest note against each bus answer
    always @(posedge clk_i) begin
        if ((rsp.rvalid && req.rready) || (rsp.bvalid && req.bready)) begin
            exp = q.pop_front();
            `CHK(rsp.rvalid ? {rsp.rdata, rsp.rresp} : {32'h0, rsp.bresp}, exp)
        end
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        q.push_back({32'h0, r});
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        do begin
            @(posedge clk_i);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        q.push_back({d, r});
        req.arvalid <= 1'b1;
        req.araddr <= a;
        do begin
            @(posedge clk_i);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic end_sim();
        $display("n_errors=%0d checked=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        req.bready <= 1'b1;
        req.rready <= 1'b1;
        void'($urandom(32'h88ec73f3));
        cy(8);
        rstn_i <= 1'b1;
        cy(1);
        // Reset values, unmapped and read-only places
        rd(`FSW_OFS_CTRL, 32'h0, OK);
        rd(`FSW_OFS_WD_TIMEOUT, 32'hfffe, OK);
        rd(8'h2c, 32'h0, `FSW_RESP_SLVERR);
        wr(`FSW_OFS_STATUS, 32'h1f, `FSW_RESP_SLVERR);
        // Inputs read as levels, outputs follow writes
        ttl_in <= 2'($urandom);
        iso_in <= 13'($urandom);
        v = $urandom;
        cy(2);
        rd(`FSW_OFS_GPI, {16'h0, 1'b1, iso_in, ttl_in}, OK);
        wr(`FSW_OFS_GPO_TTL, v, OK);
        wr(`FSW_OFS_GPO_ISO, v, OK);
        cy(2);
        `CHK({ttl_out, iso_out}, {v[9:0], v[3:0]})
        // Halt ignored while shutdown disabled
        halt_off <= 1'b1;
        cy(6);
        `CHK({proc_halt, ttl_out, iso_out}, {1'b0, v[9:0], v[3:0]})
        halt_off <= 1'b0;
        cy(3);
        // Flag action with feeding, interrupt mask and clear
        wr(`FSW_OFS_WD_TIMEOUT, 32'd3, OK);
        wr(`FSW_OFS_IRQ_MASK, 32'h3, OK);
        wr(`FSW_OFS_CTRL, 32'h8, OK);
        repeat (4) wr(`FSW_OFS_WD_FEED, 32'h0, OK);
        rd(`FSW_OFS_STATUS, 32'h0, OK);
        cy(20);
        rd(`FSW_OFS_STATUS, 32'h12, OK);
        `CHK(irq, 1'b1)
        wr(`FSW_OFS_IRQ_MASK, 32'h0, OK);
        cy(1);
        `CHK(irq, 1'b0)
        wr(`FSW_OFS_IRQ_MASK, 32'h3, OK);
        wr(`FSW_OFS_IRQ_STAT, 32'h1, OK);
        cy(1);
        `CHK(irq, 1'b0)
        wr(`FSW_OFS_CTRL, 32'h0, OK);
        rd(`FSW_OFS_STATUS, 32'h0, OK);
        // Output-line action
        wr(`FSW_OFS_GPO_TTL, 32'h0, OK);
        wr(`FSW_OFS_CTRL, 32'ha, OK);
        `CHK(ttl_out[0], 1'b0)
        cy(20);
        `CHK(ttl_out[0], 1'b1)
        wr(`FSW_OFS_CTRL, 32'h0, OK);
        cy(2);
        `CHK(ttl_out[0], 1'b0)
        // Shutdown action: every safe code, then lock
        for (int i = 0; i < 10; i++) begin
            e_out[i] = (safe[2*i +: 2] == 2'd1);
            e_oe[i] = (safe[2*i +: 2] != 2'd2);
        end
        wr(`FSW_OFS_SAFE_TTL, {12'h0, safe}, OK);
        wr(`FSW_OFS_SAFE_ISO, ~v, OK);
        wr(`FSW_OFS_CTRL, 32'hd, OK);
        cy(20);
        `CHK({ttl_out, ttl_oe, iso_out, proc_halt}, {e_out, e_oe, ~v[3:0], 1'b0})
        wr(`FSW_OFS_CTRL, 32'h0, OK);
        wr(`FSW_OFS_GPO_ISO, v, OK);
        cy(2);
        `CHK({ttl_out, ttl_oe, iso_out}, {e_out, e_oe, ~v[3:0]})
        // Power cycle, then external halt
        rstn_i <= 1'b0;
        cy(8);
        rstn_i <= 1'b1;
        cy(1);
        `CHK({proc_halt, ttl_oe}, {1'b0, 10'h3ff})
        wr(`FSW_OFS_SAFE_ISO, 32'h5, OK);
        wr(`FSW_OFS_IRQ_MASK, 32'h2, OK);
        wr(`FSW_OFS_CTRL, 32'h1, OK);
        `CHK(proc_halt, 1'b0)
        halt_off <= 1'b1;
        cy(4);
        `CHK({proc_halt, iso_out, irq}, {1'b1, 4'h5, 1'b1})
        halt_off <= 1'b0;
        wr(`FSW_OFS_CTRL, 32'h0, OK);
        cy(4);
        `CHK({proc_halt, iso_out}, {1'b1, 4'h5})
        end_sim();
    end
endmodule // fsw_top_test
`default_nettype wire
